// file: include/sar_adc_pkg.sv
/*
  shared constants, types and the conversion time table for the
  successive-approximation converter control block.
  assumes a 32-bit classic wishbone register bus and one system clock.
*/
package sar_adc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus shape
  localparam int unsigned ADR_W = 8;  // byte address width
  localparam int unsigned DAT_W = 32; // bus data width

  // register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_CTL_ONE = 8'h0E;
  localparam logic [7:0] IDX_CTL_TWO = 8'h0F;
  localparam logic [7:0] IDX_RES_HI = 8'h20;
  localparam logic [7:0] IDX_RES_LO = 8'h21;
  localparam logic [ADR_W-1:0] ADR_CTL_ONE = {IDX_CTL_ONE[5:0], 2'h0};
  localparam logic [ADR_W-1:0] ADR_CTL_TWO = {IDX_CTL_TWO[5:0], 2'h0};
  localparam logic [ADR_W-1:0] ADR_RES_HI = {IDX_RES_HI[5:0], 2'h0};
  localparam logic [ADR_W-1:0] ADR_RES_LO = {IDX_RES_LO[5:0], 2'h0};

  ////////////////////////////////////////////////////////////////////////////
  // field layouts and reset values
  localparam int unsigned RES_W = 10; // conversion result width
  localparam int unsigned CHAN_LAST = 7; // highest usable channel code
  localparam logic [7:0] CTL_ONE_INIT = 8'h10;
  localparam logic [3:0] CTL_TWO_INIT = 4'h0;
  localparam logic [RES_W-1:0] RES_INIT = 10'h000;

  // operating mode codes
  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_SOFT = 2'b01,
    MODE_RSVD = 2'b10,
    MODE_REPEAT = 2'b11
  } op_mode_t;

  // first control register: start, mode, input disable, channel
  typedef struct packed {
    logic start;
    op_mode_t mode;
    logic in_dis;
    logic [3:0] chan;
  } ctl_one_t;

  // second control register: ladder control and time select
  typedef struct packed {
    logic ladder_always;
    logic [2:0] time_sel;
  } ctl_two_t;

  // one wishbone request as seen by the slave
  typedef struct packed {
    logic we;
    logic [ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [DAT_W-1:0] dat;
  } wb_req_t;

  // converter sequencing state
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_CONV = 1'b1
  } conv_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // conversion times in system clock cycles
  localparam int unsigned CNT_W = 11;
  localparam logic [CNT_W-1:0] CONV_CYC_0 = 11'h027; // 39
  localparam logic [CNT_W-1:0] CONV_CYC_2 = 11'h04E; // 78
  localparam logic [CNT_W-1:0] CONV_CYC_3 = 11'h09C; // 156
  localparam logic [CNT_W-1:0] CONV_CYC_4 = 11'h138; // 312
  localparam logic [CNT_W-1:0] CONV_CYC_5 = 11'h270; // 624
  localparam logic [CNT_W-1:0] CONV_CYC_6 = 11'h4E0; // 1248
  localparam int unsigned CONV_CYC_MIN = 39;
  localparam int unsigned SAR_STEP_DEF = 3; // cycles per bit decision

  // cycle count for a time code; reserved codes give zero
  function automatic logic [CNT_W-1:0] conv_cycles(input logic [2:0] code);
    logic [CNT_W-1:0] c;
    c = 11'h000;
    case (code)
      3'h0: c = CONV_CYC_0;
      3'h2: c = CONV_CYC_2;
      3'h3: c = CONV_CYC_3;
      3'h4: c = CONV_CYC_4;
      3'h5: c = CONV_CYC_5;
      3'h6: c = CONV_CYC_6;
      default: c = 11'h000;
    endcase
    return c;
  endfunction : conv_cycles

endpackage : sar_adc_pkg

// file: verilog/adc_input_sync.sv
/*
  three-stage synchroniser for the comparator decision.
  assumes the input is asynchronous to clk_i; a change is passed on
  once the second and third stages agree.
*/
`timescale 1ns/1ps
module adc_input_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic async_i,
  output logic sync_o
);

  logic ff1_r; // metastable stage, read only by ff2_r
  logic ff2_r;
  logic ff3_r;

  ////////////////////////////////////////////////////////////////////////////
  // shift chain; output follows only when stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ff1_r <= 1'b0;
      ff2_r <= 1'b0;
      ff3_r <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      ff1_r <= async_i;
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
      if (ff2_r == ff3_r) begin
        sync_o <= ff3_r;
      end
    end
  end

endmodule : adc_input_sync

// file: verilog/sar_bit_engine.sv
/*
  successive-approximation register: one bit decided every STEP cycles,
  msb first, the trial code driving the dac directly.
  assumes the comparator path settles within one step.
*/
`timescale 1ns/1ps
module sar_bit_engine
  import sar_adc_pkg::*;
#(
  parameter int unsigned STEP = SAR_STEP_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i, // one-cycle pulse, begins a fresh search
  input wire logic abort_i, // stops the search
  input wire logic above_i, // input is above the trial level
  output logic [RES_W-1:0] code_o // trial code, final once search ends
);

  // the search must end before the shortest conversion time does
  if (STEP < 1 || RES_W * STEP >= CONV_CYC_MIN) begin : g_bad_step
    $error("sar step too long for the shortest conversion time");
  end

  logic [RES_W-1:0] bit_r; // one-hot bit under trial
  logic [7:0] step_r; // cycles spent on this bit
  logic active_r;
  wire step_end = active_r && (step_r == 8'(STEP - 1));
  wire [RES_W-1:0] bit_next = bit_r >> 1;
  wire [RES_W-1:0] kept = above_i ? code_o : (code_o & ~bit_r);

  ////////////////////////////////////////////////////////////////////////////
  // search sequencing
  always_ff @(posedge clk_i) begin
    if (rst_i || abort_i) begin
      bit_r <= '0;
      step_r <= 8'h00;
      active_r <= 1'b0;
      code_o <= RES_INIT;
    end else if (start_i) begin
      bit_r <= {1'b1, {(RES_W-1){1'b0}}};
      step_r <= 8'h00;
      active_r <= 1'b1;
      code_o <= {1'b1, {(RES_W-1){1'b0}}};
    end else if (step_end) begin
      // decide this bit, then raise the next one for trial
      bit_r <= bit_next;
      step_r <= 8'h00;
      active_r <= |bit_next;
      code_o <= kept | bit_next;
    end else if (active_r) begin
      step_r <= step_r + 8'h01;
    end
  end

endmodule : sar_bit_engine

// file: verilog/sar_adc_sequence_control.sv
/*
  control and result logic of an 8-channel 10-bit successive-approximation
  converter, reached over a classic wishbone slave.
  assumes the standby request comes from the system clock domain and the
  comparator decision arrives asynchronously.
  // Contract
  // - high result holds result bits nine..two
  // - low register: bits one..zero, done, busy
  // - done flag read-only, set on completion
  // - reading high result clears done flag
  // - busy set at start, cleared at end
  // - standby forces busy to zero
  // - low register bits three..zero undefined
  // - software-start mode: start runs one conversion
  // - completion loads results, done, interrupt together
  // - start bit clears once conversion starts
  // - repeat mode restarts after each completion
  // - writing disable aborts, partial result dropped
  // - completion after selected conversion time elapses
  // - new start clears done, keeps old result
  // - standby abandons conversion, resets controls, results
  // - no automatic restart after standby
  // - standby disconnects analog reference
  // - time select codes map to cycle counts
  // - mode codes off, software, repeat, reserved
  // - channel codes zero..seven, higher reserved
  // - ladder connected during conversion or always
*/
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
module sar_adc_sequence_control
  import sar_adc_pkg::*;
#(
  parameter int unsigned SAR_STEP = SAR_STEP_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [DAT_W-1:0] wb_dat_i,
  output logic [DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // system side
  input wire logic standby_i, // stop or slow standby requested
  output logic conv_done_irq_o, // one-cycle pulse per completion
  // analog side
  input wire logic comp_above_i, // asynchronous comparator decision
  output logic [RES_W-1:0] dac_code_o,
  output logic [2:0] channel_o,
  output logic analog_input_disable_o,
  output logic ladder_connect_o,
  output logic ref_disconnect_o,
  output logic converting_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  ctl_one_t ctl_one_r; // first control register
  ctl_one_t ctl_one_nxt;
  ctl_two_t ctl_two_r; // second control register
  ctl_two_t ctl_two_nxt;
  conv_state_t state_r; // idle or converting
  conv_state_t state_nxt;
  logic [CNT_W-1:0] cnt_r; // cycles since start
  logic [CNT_W-1:0] cnt_nxt;
  logic [RES_W-1:0] result_r; // last completed result
  logic [RES_W-1:0] result_nxt;
  logic done_r; // conversion done flag
  logic done_nxt;
  logic ack_r; // wishbone acknowledge
  logic [7:0] rdata_r; // read data, low byte lane
  logic [7:0] rdata_nxt;
  logic irq_r;
  logic [2:0] chan_r;
  logic in_dis_r;
  logic ladder_r;
  logic ladder_nxt;
  logic ref_dis_r;
  logic conv_r;

  wire comp_sync; // synchronised comparator decision
  wire [RES_W-1:0] sar_code; // trial code from the search engine

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wb_req_t req;
  assign req = '{we: wb_we_i, adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};

  // a request is taken in the cycle before ack rises
  wire req_take = wb_cyc_i && wb_stb_i && !ack_r;
  wire hit_one = (req.adr == ADR_CTL_ONE);
  wire hit_two = (req.adr == ADR_CTL_TWO);
  wire hit_hi = (req.adr == ADR_RES_HI);
  wire hit_lo = (req.adr == ADR_RES_LO);
  wire lane0_wr = req_take && req.we && req.sel[0];

  // control writes are locked out during standby
  wire wr_one = lane0_wr && hit_one && !standby_i;
  wire wr_two = lane0_wr && hit_two && !standby_i;
  wire rd_hi = req_take && !req.we && hit_hi;

  // incoming value for the first control register
  ctl_one_t wr_val;
  assign wr_val = ctl_one_t'(req.dat[7:0]);

  ////////////////////////////////////////////////////////////////////////////
  // conversion decode
  wire busy = (state_r == ST_CONV);
  wire [CNT_W-1:0] cyc_need = conv_cycles(ctl_two_r.time_sel);
  wire time_ok = (cyc_need != 11'h000);
  wire chan_ok = (ctl_one_r.chan <= 4'(CHAN_LAST));

  // only software start and repeat can launch a conversion
  wire mode_ok = (ctl_one_r.mode == MODE_SOFT) ||
                 (ctl_one_r.mode == MODE_REPEAT);
  wire cfg_ok = mode_ok && chan_ok && time_ok;

  // pending start bit is consumed here, launched or refused
  wire start_seen = !busy && ctl_one_r.start && !standby_i;
  wire start_go = start_seen && cfg_ok;

  // disable written while running aborts at once
  wire off_wr = wr_one && (wr_val.mode == MODE_OFF);
  wire abort = busy && (standby_i || off_wr);
  wire cnt_last = busy && (cnt_r == cyc_need - 11'h001);
  wire finish = cnt_last && !abort;

  // repeat mode starts the next conversion on the same edge
  wire restart = finish && (ctl_one_r.mode == MODE_REPEAT);
  wire sar_start = start_go || restart;

  ////////////////////////////////////////////////////////////////////////////
  // comparator synchroniser and bit search
  adc_input_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(comp_above_i),
    .sync_o(comp_sync)
  );

  sar_bit_engine #(
    .STEP(SAR_STEP)
  ) u_sar (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(sar_start),
    .abort_i(abort),
    .above_i(comp_sync),
    .code_o(sar_code)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state of the sequencer
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      ST_IDLE: begin
        cnt_nxt = 11'h000;
        if (start_go) begin
          state_nxt = ST_CONV;
        end
      end
      ST_CONV: begin
        if (abort) begin
          // partial result is simply never stored
          state_nxt = ST_IDLE;
          cnt_nxt = 11'h000;
        end else if (restart) begin
          cnt_nxt = 11'h000;
        end else if (finish) begin
          state_nxt = ST_IDLE;
          cnt_nxt = 11'h000;
        end else begin
          cnt_nxt = cnt_r + 11'h001;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        cnt_nxt = 11'h000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register next values
  always_comb begin
    ctl_one_nxt = ctl_one_r;
    ctl_two_nxt = ctl_two_r;
    if (standby_i) begin
      // standby forces both control registers to their initial values
      ctl_one_nxt = ctl_one_t'(CTL_ONE_INIT);
      ctl_two_nxt = ctl_two_t'(CTL_TWO_INIT);
    end else begin
      if (start_seen) begin
        ctl_one_nxt.start = 1'b0;
      end
      if (wr_one) begin
        ctl_one_nxt = wr_val;
        // a start written while busy or on a launch edge is dropped,
        // so a careless second start cannot queue a conversion
        ctl_one_nxt.start = wr_val.start && !busy && !start_seen;
      end
      if (wr_two) begin
        ctl_two_nxt.ladder_always = req.dat[5];
        ctl_two_nxt.time_sel = req.dat[3:1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result and done flag next values
  always_comb begin
    result_nxt = result_r;
    done_nxt = done_r;
    if (standby_i) begin
      result_nxt = RES_INIT;
      done_nxt = 1'b0;
    end else if (finish) begin
      // completion wins over a same-cycle read clear
      result_nxt = sar_code;
      done_nxt = 1'b1;
    end else if (start_go) begin
      done_nxt = 1'b0;
    end else if (rd_hi) begin
      done_nxt = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read multiplexer; unmapped addresses read zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (hit_one) begin
      rdata_nxt = ctl_one_r;
    end else if (hit_two) begin
      // bits seven and six read zero, fixed bit four reads one and fixed bit zero reads zero
      rdata_nxt = {2'h0, ctl_two_r.ladder_always, 1'b1,
                   ctl_two_r.time_sel, 1'b0};
    end else if (hit_hi) begin
      rdata_nxt = result_r[9:2];
    end else if (hit_lo) begin
      // low nibble carries no meaning and reads zero
      rdata_nxt = {result_r[1:0], done_r, busy, 4'h0};
    end
  end

  // ladder follows conversion unless held on; off in standby
  assign ladder_nxt = !standby_i &&
                      (ctl_two_r.ladder_always || busy);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer and register storage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      cnt_r <= 11'h000;
      ctl_one_r <= ctl_one_t'(CTL_ONE_INIT);
      ctl_two_r <= ctl_two_t'(CTL_TWO_INIT);
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      ctl_one_r <= ctl_one_nxt;
      ctl_two_r <= ctl_two_nxt;
    end
  end

  // results and done flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_r <= RES_INIT;
      done_r <= 1'b0;
    end else begin
      result_r <= result_nxt;
      done_r <= done_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus answer: ack one cycle after the request is taken, then dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      ack_r <= req_take;
      if (req_take) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = {24'h000000, rdata_r};

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs toward the analog and system side
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_r <= 1'b0;
      chan_r <= 3'h0;
      in_dis_r <= 1'b1;
      ladder_r <= 1'b0;
      ref_dis_r <= 1'b0;
      conv_r <= 1'b0;
    end else begin
      irq_r <= finish;
      chan_r <= ctl_one_r.chan[2:0];
      in_dis_r <= ctl_one_r.in_dis;
      ladder_r <= ladder_nxt;
      ref_dis_r <= standby_i;
      conv_r <= (state_nxt == ST_CONV);
    end
  end

  assign conv_done_irq_o = irq_r;
  assign channel_o = chan_r;
  assign analog_input_disable_o = in_dis_r;
  assign ladder_connect_o = ladder_r;
  assign ref_disconnect_o = ref_dis_r;
  assign converting_o = conv_r;
  assign dac_code_o = sar_code;

endmodule : sar_adc_sequence_control

// file: dv/sar_adc_sva.sv
/*
  concurrent checks on the ports of the converter control block.
  assumes a bind from the bench top and a single clock domain.
*/
`timescale 1ns/1ps
module sar_adc_sva
  import sar_adc_pkg::*;
#(
  parameter int unsigned SAR_STEP = SAR_STEP_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [DAT_W-1:0] wb_dat_i,
  input wire logic [DAT_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic standby_i,
  input wire logic conv_done_irq_o,
  input wire logic converting_o,
  input wire logic ref_disconnect_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////////
  // acked write into the first control register
  wire ctl1_wr = wb_ack_o && wb_we_i && wb_sel_i[0]
    && wb_adr_i == ADR_CTL_ONE;

  // a request the slave has not yet answered
  sequence s_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // standby held for two samples
  sequence s_std_held;
    standby_i [*2];
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  ack_timing_a: assert property (s_taken |=> wb_ack_o)
    else $error("no ack one cycle after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  rdata_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 0)
    else $error("read data upper bits not zero");
  standby_idle_a: assert property (standby_i |=> !converting_o)
    else $error("busy while in standby");
  ref_away_a: assert property (s_std_held |=> ref_disconnect_o)
    else $error("reference still connected in standby");
  irq_source_a: assert property (
    conv_done_irq_o |-> $past(converting_o, 2))
    else $error("interrupt without a running conversion");
  irq_pulse_a: assert property (conv_done_irq_o |=> !conv_done_irq_o)
    else $error("interrupt longer than one cycle");
  abort_stop_a: assert property (
    ctl1_wr && wb_dat_i[6:5] == 2'b00 |-> ##[0:2] !converting_o)
    else $error("disable write did not stop conversion");
  start_cause_a: assert property (
    $rose(converting_o) |-> $past(ctl1_wr) || $past(ctl1_wr, 2)
    || $past(ctl1_wr, 3))
    else $error("conversion began without a start write");
endmodule : sar_adc_sva

// file: dv/tb_sar_adc_sequence_control.sv
/*
  self-checking bench for the converter control block.
  assumes a constant comparator level gives an all-ones or all-zeros code.
*/
`timescale 1ns/1ps
module tb_sar_adc_sequence_control
  import sar_adc_pkg::*;
;
  localparam int unsigned STEP = 3; // 10 steps must stay under 39 cycles
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [ADR_W-1:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [DAT_W-1:0] wb_dat_i = 32'h00000000;
  logic [DAT_W-1:0] wb_dat_o;
  logic wb_ack_o;
  logic standby_i = 1'b0;
  logic conv_done_irq_o;
  logic comp_above_i = 1'b1; // constant level, no port noise
  logic [RES_W-1:0] dac_code_o;
  logic [2:0] channel_o;
  logic analog_input_disable_o;
  logic ladder_connect_o;
  logic ref_disconnect_o;
  logic converting_o;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  int cyc_tbl [8] = '{39, 0, 78, 156, 312, 624, 1248, 0}; // 0 = reserved

  sar_adc_sequence_control #(.SAR_STEP(STEP)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .standby_i(standby_i),
    .conv_done_irq_o(conv_done_irq_o), .comp_above_i(comp_above_i),
    .dac_code_o(dac_code_o), .channel_o(channel_o),
    .analog_input_disable_o(analog_input_disable_o),
    .ladder_connect_o(ladder_connect_o),
    .ref_disconnect_o(ref_disconnect_o), .converting_o(converting_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock and a watchdog well above the longest path
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      test_done();
    end
  end

  task automatic test_done();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  // wide enough for the longest cycle count, so nothing is cut off
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  ////////////////////////////////////////////////////////////////////////////
  // one classic cycle; request held until ack is sampled high
  task automatic xfer(input logic we, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr

  // read and compare the bits selected by the mask
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input logic [7:0] m);
    logic [7:0] q;
    xfer(1'b0, a, 8'h00, q);
    chk({2'b00, q & m}, {2'b00, e});
  endtask : rd

  // write a start and wait for busy to appear
  task automatic go(input logic [7:0] c1);
    wr(ADR_CTL_ONE, c1);
    do @(posedge clk_i); while (converting_o !== 1'b1);
  endtask : go

  // a start that must be refused leaves the converter idle
  task automatic no_start(input logic [7:0] c1);
    wr(ADR_CTL_ONE, c1);
    repeat (8) @(posedge clk_i);
    chk(converting_o, 1'b0);
  endtask : no_start

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(ADR_CTL_ONE, 8'h10, 8'hFF);
    rd(ADR_CTL_TWO, 8'h10, 8'hFF);
    rd(ADR_RES_HI, 8'h00, 8'hFF);
    rd(ADR_RES_LO, 8'h00, 8'hF0);
    wr(8'h40, 8'hFF);
    rd(8'h40, 8'h00, 8'hFF);
  endtask : t_reset

  // every usable time code: busy length, interrupt, results, flags; reserved codes must refuse to start
  task automatic t_times();
    int n;
    for (int c = 0; c < 8; c++) begin
      wr(ADR_CTL_TWO, 8'h10 | 8'(c << 1));
      if (cyc_tbl[c] == 0) no_start(8'hA3);
      else begin
        n = 1;
        go(8'hA3);
        while (converting_o === 1'b1) begin
          if (n == 5) begin
            chk(channel_o, 3'h3);
            chk(ladder_connect_o, 1'b1);
            chk(analog_input_disable_o, 1'b0);
          end
          n++;
          @(posedge clk_i);
        end
        chk(n - 1, cyc_tbl[c]);
        // interrupt shows on the same edge that busy is first seen low
        chk(conv_done_irq_o, 1'b1);
        chk(dac_code_o, 10'h3FF);
        @(posedge clk_i);
        chk(conv_done_irq_o, 1'b0);
        rd(ADR_CTL_ONE, 8'h23, 8'hFF);
        rd(ADR_RES_LO, 8'hE0, 8'hF0);
        rd(ADR_RES_HI, 8'hFF, 8'hFF);
        rd(ADR_RES_LO, 8'hC0, 8'hF0);
        chk(ladder_connect_o, 1'b0);
      end
    end
  endtask : t_times

  task automatic t_refuse();
    wr(ADR_CTL_TWO, 8'h10);
    no_start(8'h83);
    no_start(8'hC3);
    no_start(8'hA8);
  endtask : t_refuse

  // restart before reading: done drops, old result kept
  task automatic t_keep();
    wr(ADR_CTL_TWO, 8'h16);
    go(8'hA3);
    do @(posedge clk_i); while (converting_o === 1'b1);
    comp_above_i <= 1'b0;
    go(8'hA3);
    rd(ADR_RES_LO, 8'hD0, 8'hF0);
    rd(ADR_RES_HI, 8'hFF, 8'hFF);
    do @(posedge clk_i); while (converting_o === 1'b1);
    rd(ADR_RES_LO, 8'h20, 8'hF0);
    rd(ADR_RES_HI, 8'h00, 8'hFF);
  endtask : t_keep

  // repeat mode restarts, disable aborts without storing
  task automatic t_repeat();
    comp_above_i <= 1'b1;
    wr(ADR_CTL_TWO, 8'h10);
    go(8'hE3);
    repeat (2) begin
      do @(posedge clk_i); while (conv_done_irq_o !== 1'b1);
      chk(converting_o, 1'b1);
    end
    rd(ADR_RES_HI, 8'hFF, 8'hFF);
    comp_above_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    wr(ADR_CTL_ONE, 8'h03);
    repeat (2) @(posedge clk_i);
    chk(converting_o, 1'b0);
    rd(ADR_RES_HI, 8'hFF, 8'hFF);
  endtask : t_repeat

  // standby in mid-conversion wipes controls and results
  task automatic t_standby();
    comp_above_i <= 1'b1;
    wr(ADR_CTL_TWO, 8'h3D);
    repeat (3) @(posedge clk_i);
    chk(ladder_connect_o, 1'b1);
    go(8'hA3);
    repeat (10) @(posedge clk_i);
    standby_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(converting_o, 1'b0);
    chk(ref_disconnect_o, 1'b1);
    wr(ADR_CTL_ONE, 8'hA3);
    standby_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rd(ADR_CTL_ONE, 8'h10, 8'hFF);
    rd(ADR_CTL_TWO, 8'h10, 8'hFF);
    rd(ADR_RES_HI, 8'h00, 8'hFF);
    rd(ADR_RES_LO, 8'h00, 8'hF0);
    repeat (40) @(posedge clk_i);
    chk(converting_o, 1'b0);
  endtask : t_standby

  ////////////////////////////////////////////////////////////////////////////
  // main sequence: reset for ten cycles, then each scenario in turn
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_times();
    t_refuse();
    t_keep();
    t_repeat();
    t_standby();
    test_done();
  end
endmodule : tb_sar_adc_sequence_control

// checker sits on the top module's ports
bind sar_adc_sequence_control sar_adc_sva #(.SAR_STEP(SAR_STEP)) chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .standby_i(standby_i), .conv_done_irq_o(conv_done_irq_o),
  .converting_o(converting_o), .ref_disconnect_o(ref_disconnect_o)
);
